// File: dv/core_status_pc_stack_asserts.sv
/* checker on the block ports
   assumes the bind below */
`timescale 1ns/1ps
module core_chk
	import core_ctl_pkg::*;
(
	// inputs
	input wire logic clk,
	input wire logic srst,
	input wire logic instr_en,
	input wire flow_op_t flow_op,
	input wire logic [10:0] jump_target,
	input wire file_wr_t file_wr,
	input wire alu_flags_t alu_flags,
	input wire pwr_evt_t pwr_evt,
	// outputs
	input wire logic [12:0] pc,
	input wire logic [7:0] status,
	input wire logic bank_sel_low,
	input wire logic [7:0] prog_counter_upper_latch
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire logic sw = file_wr.wr && file_wr.addr[6:0] == ADDR_STATUS;
	wire logic pw = file_wr.wr && file_wr.addr[6:0] == ADDR_PCL;
	wire logic jc = instr_en && flow_op inside {FLOW_JUMP, FLOW_CALL};
	rst_clear_a:
	assert property ($fell(srst) |-> pc == PC_RST) else $error("pc kept");
	bank_out_a:
	assert property (bank_sel_low == status[BIT_RP0]) else $error("bank");
	jump_load_a:
	assert property (jc |=> pc == {$past(prog_counter_upper_latch[4:3]),
		$past(jump_target)}) else $error("jump");
	pcl_load_a:
	assert property (pw && !file_wr.clear_op && instr_en &&
		flow_op == FLOW_STEP |=> pc == {$past(prog_counter_upper_latch[4:0]),
		$past(file_wr.data)}) else $error("pcl load");
	wd_bits_a:
	assert property (sw && pwr_evt == '0 |=> $stable(status[4:3]))
		else $error("bits 4:3");
	flag_win_a:
	assert property (alu_flags.upd_z |=> status[BIT_Z] == $past(alu_flags.z))
		else $error("zero flag");
	clr_stat_a:
	assert property (sw && file_wr.clear_op && alu_flags == '0 |=>
		status[7:5] == 3'h0 && status[BIT_Z]) else $error("clear");
	irq_vec_a:
	assert property (instr_en && flow_op == FLOW_IRQ |=> pc == IRQ_VECTOR)
		else $error("vector");
	latch_keep_a:
	assert property (instr_en && flow_op inside {FLOW_CALL, FLOW_RET} &&
		!file_wr.wr |=> $stable(prog_counter_upper_latch)) else $error("latch");
	cover property (jc);
	cover property (instr_en && flow_op == FLOW_RET);
	cover property (sw && file_wr.clear_op);
endmodule
bind core_status_pc_stack core_chk u_chk (.*);

// File: dv/core_status_pc_stack_tb.sv
/* bench: register access, flow ops, stack wrap
   assumes dec_model and the checker */
`timescale 1ns/1ps
module core_status_pc_stack_tb;
	import core_ctl_pkg::*;
	logic clk = 1'h0, srst = 1'h1, rd_en = 1'h0, instr_en, bank_sel_low;
	logic [7:0] rd_addr = 8'h0, rd_data, status, prog_counter_upper_latch;
	logic [12:0] pc;
	logic [10:0] jump_target;
	flow_op_t flow_op;
	file_wr_t file_wr = '0;
	alu_flags_t alu_flags = '0;
	pwr_evt_t pwr_evt = '0;
	int errors = 0, n_compared = 0, cyc = 0;
	always #2.5 clk = ~clk;
	dec_model dec (.*);
	core_status_pc_stack uut (.*);
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d, input logic c = 1'h0);
		@(posedge clk);
		file_wr <= '{1'h1, a, d, c};
		@(posedge clk);
		file_wr.wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [12:0] e);
		@(posedge clk);
		rd_en <= 1'h1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'h0;
		#1 cmp({5'h0, rd_data}, e);
	endtask
	task test_done;
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			errors++;
			test_done;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		#1 cmp(pc, 13'h0);
		wr(8'h8a, 8'h07);
		wr(8'h83, 8'h00);
		rd(8'h03, 13'h18);
		fork
			wr(8'h03, 8'h27);
			@(posedge clk) alu_flags <= 6'h20;
		join
		alu_flags <= 6'h0;
		rd(8'h83, 13'h3b);
		cmp(bank_sel_low, 13'h1);
		wr(8'h03, 8'h00, 1'h1);
		rd(8'h03, 13'h1f);
		fork
			dec.run(FLOW_STEP, 11'h0);
			wr(8'h02, 8'h34);
		join
		#1 cmp(pc, 13'h0734);
		rd(8'h82, 13'h34);
		dec.run(FLOW_CALL, 11'h700);
		#1 cmp(pc, 13'h0700);
		for (int i = 1; i <= 8; i++)
			dec.run(FLOW_CALL, 11'(i));
		for (int i = 8; i >= 2; i--) begin
			dec.run(FLOW_RET, 11'h0);
			#1 cmp(pc, 13'(i));
		end
		dec.run(FLOW_RET, 11'h0);
		#1 cmp(pc, 13'h0701);
		dec.run(FLOW_RET, 11'h0);
		#1 cmp(pc, 13'h0008);
		rd(8'h03, 13'h1f);
		rd(8'h0a, 13'h07);
		wr(8'h0a, 8'h18);
		#1 cmp(prog_counter_upper_latch, 13'h18);
		fork
			dec.run(FLOW_STEP, 11'h0);
			wr(8'h02, 8'hff);
		join
		#1 cmp(pc, 13'h18ff);
		dec.run(FLOW_JUMP, 11'h123);
		#1 cmp(pc, 13'h1923);
		dec.run(FLOW_IRQ, 11'h0);
		#1 cmp(pc, IRQ_VECTOR);
		rd(8'h05, 13'h0);
		@(posedge clk) pwr_evt <= 4'h2;
		@(posedge clk) pwr_evt <= 4'h1;
		@(posedge clk) pwr_evt <= 4'h0;
		#1 cmp(status, 13'h07);
		@(posedge clk) alu_flags <= 6'h19;
		@(posedge clk) alu_flags <= 6'h0;
		#1 cmp(status, 13'h05);
		@(posedge clk) pwr_evt <= 4'h4;
		@(posedge clk) pwr_evt <= 4'h0;
		#1 cmp(status, 13'h1d);
		@(posedge clk) srst <= 1'h1;
		@(posedge clk) srst <= 1'h0;
		#1 cmp(pc, 13'h0);
		cmp(status, 13'h18);
		test_done;
	end
endmodule

// File: dv/dec_model.sv
/* decoder model: issues one flow op per call
   assumes clk from the bench */
`timescale 1ns/1ps
module dec_model
	import core_ctl_pkg::*;
(
	// clock and instruction stream
	input wire logic clk,
	output logic instr_en,
	output flow_op_t flow_op,
	output logic [10:0] jump_target
);
	initial begin
		instr_en = 1'h0;
		flow_op = FLOW_STEP;
		jump_target = 11'h0;
	end
	// one enabled cycle per op
	task automatic run(input flow_op_t op, input logic [10:0] t);
		@(posedge clk);
		instr_en <= 1'h1;
		flow_op <= op;
		jump_target <= t;
		@(posedge clk);
		instr_en <= 1'h0;
	endtask
endmodule

// File: src/core_ctl_pkg.sv
/*
 * constants, types and register map for the core status, program counter
 * and return stack block; assumes a decoder and alu on the same clock
 */
package core_ctl_pkg;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int PTR_W = 3;
	// file addresses of the registers in bank 0; bit 7 is the bank bit
	localparam logic [6:0] ADDR_PCL = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_PROG_COUNTER_UPPER_LATCH = 7'h0a;
	// status bit positions
	localparam int BIT_C = 0;
	localparam int BIT_DC = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_PD = 3;
	localparam int BIT_TO = 4;
	localparam int BIT_RP0 = 5;
	localparam int BIT_RP1 = 6;
	localparam int BIT_IRP = 7;
	// upper latch field positions
	localparam int LATH_LOAD_HI = 4;
	localparam int LATH_JUMP_LO = 3;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] PROG_COUNTER_UPPER_LATCH_RST = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;

	typedef enum logic [2:0] {
		FLOW_STEP,
		FLOW_JUMP,
		FLOW_CALL,
		FLOW_RET,
		FLOW_IRQ
	} flow_op_t;

	// one file-register write from the datapath
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
		logic clear_op;
	} file_wr_t;

	// flag results of the current alu instruction
	typedef struct packed {
		logic upd_z;
		logic upd_dc;
		logic upd_c;
		logic z;
		logic dc;
		logic c;
	} alu_flags_t;

	// power-state events
	typedef struct packed {
		logic por;
		logic wdt_clear;
		logic sleep;
		logic wdt_timeout;
	} pwr_evt_t;
endpackage

// File: src/core_status_pc_stack.sv
/*
 * status register, 13-bit program counter with low byte and upper latch,
 * and the 8-deep circular return stack of the core.
 * assumes the decoder presents one instruction per enabled cycle, all
 * inputs synchronous to clk, and subtraction carries already given in
 * the no-borrow sense by the alu.
 */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - alu flag updates override explicit status writes
// - watchdog and sleep bits ignore writes
// - clear of status clears top, sets zero
// - low bank bit selects direct bank
// - status reachable at 03h and 83h
// - subtraction carries mean no borrow
// - 13-bit counter, low byte readable writable
// - upper counter bits only from latch
// - srst clears program counter; por event does not
// - low byte write loads latch bits upward
// - call or jump takes latch bits 4:3
// - hidden 8x13 return stack
// - push on call or interrupt
// - pop on any return
// - stack actions leave latch alone
// - stack wraps circularly over eight entries
// - no overflow or underflow flag
module core_status_pc_stack
	import core_ctl_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// instruction stream
	input wire logic instr_en,
	input wire flow_op_t flow_op,
	input wire logic [10:0] jump_target,
	// file register access
	input wire file_wr_t file_wr,
	input wire logic [7:0] rd_addr,
	input wire logic rd_en,
	input wire alu_flags_t alu_flags,
	input wire pwr_evt_t pwr_evt,
	// outputs
	output logic [7:0] rd_data,
	output logic [12:0] pc,
	output logic [7:0] status,
	output logic bank_sel_low,
	output logic [7:0] prog_counter_upper_latch
);
	logic [7:0] status_q, status_d;
	logic [7:0] lath_q, lath_d;
	logic [12:0] pc_q, pc_d;
	logic [PTR_W-1:0] sp_q, sp_d;
	logic [12:0] stack_q [DEPTH];
	logic push, pop;
	logic [7:0] rd_data_q, rd_data_d;

	// both banks map the same core registers
	function automatic logic hit(input logic [7:0] a, input logic [6:0] r);
		hit = (a[6:0] == r);
	endfunction

	// call and jump share one target composition
	function automatic logic [12:0] jump_dest(input logic [7:0] l,
		input logic [10:0] t);
		jump_dest = {l[LATH_LOAD_HI:LATH_JUMP_LO], t};
	endfunction

	// the low byte write pulls the five latch bits into the high byte
	function automatic logic [12:0] pcl_dest(input logic [7:0] l,
		input logic [7:0] d);
		pcl_dest = {l[LATH_LOAD_HI:0], d};
	endfunction

	logic wr_status, wr_pcl, wr_lath;
	assign wr_status = file_wr.wr && hit(file_wr.addr, ADDR_STATUS);
	assign wr_pcl = file_wr.wr && hit(file_wr.addr, ADDR_PCL);
	assign wr_lath = file_wr.wr && hit(file_wr.addr, ADDR_PROG_COUNTER_UPPER_LATCH);

	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			if (file_wr.clear_op) begin
				status_d[7:5] = 3'h0;
				status_d[BIT_Z] = 1'b1;
			end else begin
				status_d[7:5] = file_wr.data[7:5];
				status_d[2:0] = file_wr.data[2:0];
			end
			// bits 4 and 3 are never taken from the bus
		end
		// alu result wins over the explicit write
		// carries arrive as no-borrow on subtraction
		if (alu_flags.upd_z) begin
			status_d[BIT_Z] = alu_flags.z;
		end
		if (alu_flags.upd_dc) begin
			status_d[BIT_DC] = alu_flags.dc;
		end
		if (alu_flags.upd_c) begin
			status_d[BIT_C] = alu_flags.c;
		end
		if (pwr_evt.por || pwr_evt.wdt_clear) begin
			status_d[BIT_TO] = 1'b1;
			status_d[BIT_PD] = 1'b1;
		end else if (pwr_evt.sleep) begin
			status_d[BIT_TO] = 1'b1;
			status_d[BIT_PD] = 1'b0;
		end
		if (pwr_evt.wdt_timeout) begin
			status_d[BIT_TO] = 1'b0;
		end
	end

	// pushes and pops never touch the latch
	always_comb begin
		lath_d = lath_q;
		if (wr_lath) begin
			lath_d = file_wr.clear_op ? 8'h00 : file_wr.data;
		end
	end

	always_comb begin
		pc_d = pc_q;
		sp_d = sp_q;
		push = 1'b0;
		pop = 1'b0;
		if (instr_en) begin
			pc_d = pc_q + 13'h0001;
			case (flow_op)
				FLOW_JUMP: begin
					pc_d = jump_dest(lath_q, jump_target);
				end
				FLOW_CALL: begin
					push = 1'b1;
					pc_d = jump_dest(lath_q, jump_target);
				end
				FLOW_IRQ: begin
					push = 1'b1;
					pc_d = IRQ_VECTOR;
				end
				FLOW_RET: begin
					pop = 1'b1;
					pc_d = stack_q[sp_q - 3'h1];
				end
				default: begin
					if (wr_pcl) begin
						pc_d = pcl_dest(lath_q,
							file_wr.clear_op ? 8'h00 : file_wr.data);
					end
				end
			endcase
			// pointer wraps silently with no flag
			if (push) begin
				sp_d = sp_q + 3'h1;
			end else if (pop) begin
				sp_d = sp_q - 3'h1;
			end
		end
	end

	always_comb begin
		rd_data_d = 8'h00;
		if (rd_en) begin
			if (hit(rd_addr, ADDR_PCL)) begin
				rd_data_d = pc_q[7:0];
			end else if (hit(rd_addr, ADDR_STATUS)) begin
				rd_data_d = status_q;
			end else if (hit(rd_addr, ADDR_PROG_COUNTER_UPPER_LATCH)) begin
				rd_data_d = lath_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			status_q <= STATUS_RST;
			lath_q <= PROG_COUNTER_UPPER_LATCH_RST;
			pc_q <= PC_RST;
			sp_q <= '0;
			rd_data_q <= 8'h00;
		end else begin
			status_q <= status_d;
			lath_q <= lath_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
			rd_data_q <= rd_data_d;
		end
	end

	// one write enable per entry, the pointer picks the slot
	logic [DEPTH-1:0] slot_we;
	logic [12:0] ret_addr;
	assign ret_addr = pc_q + 13'h0001;

	always_comb begin
		slot_we = '0;
		if (push) begin
			slot_we[sp_q] = 1'b1;
		end
	end

	// hidden stack storage
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk) begin
			if (slot_we[i]) begin
				stack_q[i] <= ret_addr;
			end
		end
	end

	assign rd_data = rd_data_q;
	assign pc = pc_q;
	assign status = status_q;
	assign bank_sel_low = status_q[BIT_RP0];
	assign prog_counter_upper_latch = lath_q;
endmodule
